// ---- rtl/paux_jabber.sv ----
// Jabber watchdog: counts a continuous transmit request and flags overrun
`timescale 1ns/1ps
module paux_jabber #(
    parameter int LIMIT = 800000
) (
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    input  wire logic i_enable,
    input  wire logic i_tx_req,
    output logic      o_jabber
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        jab;
    } paux_jab_st_t;
    paux_jab_st_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (!i_enable || !i_tx_req) begin
            st_nxt.cnt = 32'h0;
            st_nxt.jab = 1'b0;
        end else if (st_r.cnt >= 32'(LIMIT - 1)) begin
            st_nxt.jab = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 32'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_jabber = st_r.jab;
endmodule

// ---- rtl/paux_pkg.sv ----
// Package: register map, fields and timing for the PHY auxiliary control registers
package paux_pkg;
    // MII management register addresses (any free vendor slots)
    localparam logic [4:0] ADDR_AUX_CTRL_STAT = 5'h18;
    localparam logic [4:0] ADDR_AUX_MODE      = 5'h1D;
    localparam logic [4:0] ADDR_AUX_MULTI_PHY = 5'h1B;
    // Field positions
    localparam int FLD_EDGE_LO   = 4;
    localparam int FLD_SQ_LO     = 6;
    localparam int FLD_LINK_DIS  = 14;
    localparam int FLD_JAB_DIS   = 15;
    localparam int FLD_BLK_TXEN  = 1;
    localparam int FLD_LLED_DIS  = 3;
    localparam int FLD_ALED_DIS  = 4;
    // Writable masks; fixed-zero positions are left out
    localparam logic [15:0] MASK_AUX_CTRL  = 16'hC0F0;
    localparam logic [15:0] MASK_AUX_MODE  = 16'h001A;
    localparam logic [15:0] MASK_AUX_MULTI = 16'h000B;
    localparam logic [15:0] RST_AUX_CTRL   = 16'h0000;
    localparam logic [15:0] RST_AUX_MODE   = 16'h0000;
    localparam logic [15:0] RST_AUX_MULTI  = 16'h0000;
    // Read-only status bit positions of the multiple-PHY register
    localparam logic [15:0] MASK_MULTI_RO  = 16'hF9F0;
    // Jabber limit, in microseconds, and cycles at 40 MHz
    localparam int CLK_MHZ     = 40;
    localparam int JAB_US      = 20000;
    localparam int JAB_CYCLES  = JAB_US * CLK_MHZ;
    // Gap window for block-transmit-enable idle insertion
    localparam int BLK_GAP_MAX = 4;
    localparam int BLK_IDLES   = 2;
    // Edge-rate codes in ns
    localparam logic [2:0] EDGE_1NS = 3'h1;
    localparam logic [2:0] EDGE_2NS = 3'h2;
    localparam logic [2:0] EDGE_3NS = 3'h3;
    localparam logic [2:0] EDGE_4NS = 3'h4;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } paux_mgmt_req_t;

    typedef struct packed {
        logic tx_activity;
        logic rx_activity;
        logic link_up;
    } paux_led_t;
endpackage

// ---- rtl/paux_regs.sv ----
// PHY auxiliary control, squelch, link/jabber disables and auxiliary mode registers
`timescale 1ns/1ps
module paux_regs
    import paux_pkg::*;
#(
    parameter int JAB_LIMIT = paux_pkg::JAB_CYCLES
) (
    // Clock and reset
    input  wire logic                     I_REF_CLK,
    input  wire logic                     I_ARST_N,
    // Management access (from the MII management frame decoder)
    input  wire paux_pkg::paux_mgmt_req_t I_MGMT_REQ,
    output logic [15:0]                   O_MGMT_RDATA,
    output logic                          O_MGMT_RVALID,
    // Pins and mode
    input  wire logic [1:0]               I_EDGE_RATE_PINS,
    input  wire logic                     I_SPEED_100,
    input  wire logic [15:0]              I_MULTI_STATUS,
    // Transmit path
    input  wire logic                     I_TX_REQ,
    input  wire logic                     I_TX_SYM_EN,
    output logic                          O_TX_DRIVE,
    output logic                          O_INSERT_IDLE,
    output logic                          O_JABBER,
    // Edge rate and squelch
    output logic [1:0]                    O_EDGE_RATE_CTRL,
    output logic [2:0]                    O_EDGE_NS,
    output logic [1:0]                    O_SQUELCH_ADJUST,
    // Link integrity
    input  wire logic                     I_LINK_PASS_RAW,
    output logic                          O_LINK_SM_HALT,
    output logic                          O_LINK_PASS,
    // LEDs
    input  wire paux_pkg::paux_led_t      I_LED_SRC,
    output logic                          O_LINK_INDICATOR_OUTPUT,
    output logic                          O_TRANSMIT_ACTIVITY_LED_N,
    output logic                          O_RECEIVE_ACTIVITY_LED_N
);
    import paux_pkg::*;

    typedef struct packed {
        logic [1:0]  er_s1;
        logic [1:0]  er_s2;
        logic [15:0] ctrl;
        logic [15:0] mode;
        logic [15:0] multi;
        logic [15:0] rdata;
        logic        rvalid;
        logic        prev_txreq;
        logic [2:0]  gap;
        logic [1:0]  idle_left;
    } paux_st_t;

    paux_st_t st_r, st_nxt;
    logic     jabber;
    logic     jab_en;

    function automatic logic [2:0] edge_ns(input logic [1:0] code);
        case (code)
            2'h0:    edge_ns = EDGE_1NS;
            2'h1:    edge_ns = EDGE_2NS;
            2'h2:    edge_ns = EDGE_3NS;
            default: edge_ns = EDGE_4NS;
        endcase
    endfunction

    assign jab_en = !st_r.ctrl[FLD_JAB_DIS] && !I_SPEED_100;

    paux_jabber #(
        .LIMIT (JAB_LIMIT)
    ) u_jabber (
        .i_clk    (I_REF_CLK),
        .i_arst_n (I_ARST_N),
        .i_enable (jab_en),
        .i_tx_req (I_TX_REQ),
        .o_jabber (jabber)
    );

    always_comb begin
        st_nxt        = st_r;
        st_nxt.er_s1  = I_EDGE_RATE_PINS;
        st_nxt.er_s2  = st_r.er_s1;
        st_nxt.rvalid = 1'b0;
        // Management writes keep only writable positions
        if (I_MGMT_REQ.wr) begin
            case (I_MGMT_REQ.addr)
                ADDR_AUX_CTRL_STAT: st_nxt.ctrl  = I_MGMT_REQ.wdata & MASK_AUX_CTRL;
                ADDR_AUX_MODE:      st_nxt.mode  = I_MGMT_REQ.wdata & MASK_AUX_MODE;
                ADDR_AUX_MULTI_PHY: st_nxt.multi = I_MGMT_REQ.wdata & MASK_AUX_MULTI;
                default: ;
            endcase
        end
        if (I_MGMT_REQ.rd) begin
            st_nxt.rvalid = 1'b1;
            case (I_MGMT_REQ.addr)
                ADDR_AUX_CTRL_STAT: st_nxt.rdata = st_r.ctrl;
                ADDR_AUX_MODE:      st_nxt.rdata = st_r.mode;
                ADDR_AUX_MULTI_PHY: st_nxt.rdata = st_r.multi | (I_MULTI_STATUS & MASK_MULTI_RO);
                default:            st_nxt.rdata = 16'h0000;
            endcase
        end
        // Block TXEN: short gap yields exactly two idles, starting the cycle after the next start is driven
        st_nxt.prev_txreq = I_TX_REQ;
        if (I_TX_SYM_EN) begin
            if (!I_TX_REQ) begin
                if (st_r.gap != 3'h7) begin
                    st_nxt.gap = st_r.gap + 3'h1;
                end
            end else if (!st_r.prev_txreq && st_r.mode[FLD_BLK_TXEN]
                         && st_r.gap != 3'h0 && st_r.gap <= 3'(BLK_GAP_MAX)) begin
                st_nxt.idle_left = 2'(BLK_IDLES);
                st_nxt.gap       = 3'h0;
            end else begin
                st_nxt.gap = 3'h0;
            end
            if (st_r.idle_left != 2'h0) begin
                st_nxt.idle_left = st_r.idle_left - 2'h1;
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_r       <= '0;
            st_r.ctrl  <= RST_AUX_CTRL;
            st_r.mode  <= RST_AUX_MODE;
            st_r.multi <= RST_AUX_MULTI;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign O_MGMT_RDATA     = st_r.rdata;
    assign O_MGMT_RVALID    = st_r.rvalid;
    assign O_EDGE_RATE_CTRL = st_r.ctrl[FLD_EDGE_LO +: 2] & st_r.er_s2;
    assign O_EDGE_NS        = edge_ns(O_EDGE_RATE_CTRL);
    assign O_SQUELCH_ADJUST = st_r.ctrl[FLD_SQ_LO +: 2];
    assign O_LINK_SM_HALT   = st_r.ctrl[FLD_LINK_DIS];
    assign O_LINK_PASS      = st_r.ctrl[FLD_LINK_DIS] | I_LINK_PASS_RAW;
    assign O_JABBER         = jabber;
    assign O_TX_DRIVE       = I_TX_REQ && !jabber && (st_r.idle_left == 2'h0);
    assign O_INSERT_IDLE    = st_r.idle_left != 2'h0;
    assign O_LINK_INDICATOR_OUTPUT   = I_LED_SRC.link_up && !st_r.mode[FLD_LLED_DIS];
    assign O_TRANSMIT_ACTIVITY_LED_N = !(I_LED_SRC.tx_activity && !st_r.mode[FLD_ALED_DIS]);
    assign O_RECEIVE_ACTIVITY_LED_N  = !(I_LED_SRC.rx_activity && !st_r.mode[FLD_ALED_DIS]);
endmodule

// ---- tb/paux_mgmt_model.sv ----
// Station management controller issuing one-cycle register requests
`timescale 1ns/1ps
module paux_mgmt_model
    import paux_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rdata,
    output paux_mgmt_req_t   o_req
);
    initial o_req = '0;
    task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
        @(negedge i_clk);
        o_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge i_clk);
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        q = i_rdata;
    endtask
endmodule

// ---- tb/paux_regs_monitor.sv ----
// Port assertions for the auxiliary register block
`timescale 1ns/1ps
module paux_regs_monitor
    import paux_pkg::*;
(
    input wire logic           I_REF_CLK, I_ARST_N, I_SPEED_100, I_TX_REQ, I_LINK_PASS_RAW,
    input wire paux_mgmt_req_t I_MGMT_REQ,
    input wire logic [1:0]     I_EDGE_RATE_PINS, O_EDGE_RATE_CTRL,
    input wire logic [2:0]     O_EDGE_NS,
    input wire logic [15:0]    O_MGMT_RDATA,
    input wire logic           O_MGMT_RVALID, O_TX_DRIVE, O_INSERT_IDLE, O_JABBER, O_LINK_SM_HALT, O_LINK_PASS
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_ARST_N);
    pin_gate_a: assert property ((I_EDGE_RATE_PINS == 2'h0) [*4] |-> O_EDGE_RATE_CTRL == 2'h0)
        else $error("edge control passed a low pin");
    edge_code_a: assert property (O_EDGE_NS == 3'(O_EDGE_RATE_CTRL) + 3'h1)
        else $error("edge time code wrong");
    link_force_a: assert property (O_LINK_PASS == (O_LINK_SM_HALT || I_LINK_PASS_RAW))
        else $error("link pass wrong");
    tx_gate_a: assert property (O_TX_DRIVE |-> I_TX_REQ && !O_JABBER && !O_INSERT_IDLE)
        else $error("transmitter driven when it must not be");
    jab_drop_a: assert property (!I_TX_REQ |=> !O_JABBER)
        else $error("jabber held without request");
    jab_speed_a: assert property (I_SPEED_100 [*2] |-> !O_JABBER)
        else $error("jabber at 100 Mb/s");
    read_time_a: assert property (O_MGMT_RVALID == $past(I_MGMT_REQ.rd))
        else $error("read answer late or spurious");
    mode_zero_a: assert property (O_MGMT_RVALID && $past(I_MGMT_REQ.addr) == ADDR_AUX_MODE
        |-> (O_MGMT_RDATA & ~MASK_AUX_MODE) == 16'h0000)
        else $error("fixed-zero mode bit read as one");
    cover property (O_JABBER);
    cover property (O_INSERT_IDLE);
    cover property (O_LINK_SM_HALT);
endmodule
bind paux_regs paux_regs_monitor mon_u (.*);

// ---- tb/paux_regs_tb.sv ----
// Self-checking bench for the auxiliary register block
`timescale 1ns/1ps
module paux_regs_tb;
    import paux_pkg::*;
    logic clk = 0, arst_n = 0, spd = 1, txr = 0, raw = 0, rv, drv, idl, jab, hlt, pas, lnk, txn, rxn;
    logic [1:0] pins = 2'h0, ec, sq;
    logic [2:0] ns;
    logic [15:0] q, rdata;
    paux_mgmt_req_t req;
    int mismatches = 0, checks_done = 0;
    always #12.5 clk = ~clk;
    paux_mgmt_model mgmt_u (.i_clk(clk), .i_rdata(rdata), .o_req(req));
    paux_regs #(.JAB_LIMIT(16)) dut_u (.I_REF_CLK(clk), .I_ARST_N(arst_n), .I_MGMT_REQ(req),
        .O_MGMT_RDATA(rdata), .O_MGMT_RVALID(rv), .I_EDGE_RATE_PINS(pins), .I_SPEED_100(spd),
        .I_MULTI_STATUS(16'h0000), .I_TX_REQ(txr), .I_TX_SYM_EN(1'b1), .O_TX_DRIVE(drv), .O_INSERT_IDLE(idl),
        .O_JABBER(jab), .O_EDGE_RATE_CTRL(ec), .O_EDGE_NS(ns), .O_SQUELCH_ADJUST(sq), .I_LINK_PASS_RAW(raw),
        .O_LINK_SM_HALT(hlt), .O_LINK_PASS(pas), .I_LED_SRC(3'h7), .O_LINK_INDICATOR_OUTPUT(lnk),
        .O_TRANSMIT_ACTIVITY_LED_N(txn), .O_RECEIVE_ACTIVITY_LED_N(rxn));
    task automatic chk(input string n, input logic [15:0] s, e);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        mgmt_u.xfer(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] m, e);
        mgmt_u.xfer(1'b0, a, 16'h0000, q);
        chk("read", q & m, e);
    endtask
    task automatic t_regs;
        rdc(ADDR_AUX_CTRL_STAT, 16'hFFFF, 16'h0000);
        wr(ADDR_AUX_MODE, 16'hFFFF);
        rdc(ADDR_AUX_MODE, 16'hFFFF, MASK_AUX_MODE);
        wr(ADDR_AUX_MULTI_PHY, 16'hFFFF);
        rdc(ADDR_AUX_MULTI_PHY, 16'hFFFF, 16'h000B);
        wr(ADDR_AUX_CTRL_STAT, 16'hFFFF);
        rdc(ADDR_AUX_CTRL_STAT, 16'hFFFF, 16'hC0F0);
        wr(ADDR_AUX_CTRL_STAT, 16'hC0C0);
        rdc(ADDR_AUX_CTRL_STAT, MASK_AUX_CTRL, 16'hC0C0);
        chk("squelch", 16'(sq), 16'h0003);
        rdc(5'h05, 16'hFFFF, 16'h0000);
        @(negedge clk) arst_n = 0;
        @(negedge clk) arst_n = 1;
        rdc(ADDR_AUX_CTRL_STAT, 16'hFFFF, 16'h0000);
        $display("regs done");
    endtask
    task automatic t_edge;
        wr(ADDR_AUX_CTRL_STAT, 16'h0030);
        for (int p = 0; p < 4; p++) begin
            pins = 2'(p);
            repeat (4) @(negedge clk);
            chk("edge", 16'(ec), 16'(p));
            chk("ns", 16'(ns), 16'(p + 1));
        end
        wr(ADDR_AUX_CTRL_STAT, 16'h4000);
        chk("link", 16'({hlt, pas}), 16'h0003);
        wr(ADDR_AUX_CTRL_STAT, 16'h0000);
        chk("link", 16'({hlt, pas}), 16'h0000);
        $display("edge done");
    endtask
    task automatic t_led;
        logic [15:0] v [3] = '{16'h0018, 16'h0008, 16'h0000};
        foreach (v[i]) begin
            wr(ADDR_AUX_MODE, v[i]);
            chk("lnk", 16'(lnk), 16'(!v[i][3]));
            chk("act", 16'({txn, rxn}), v[i][4] ? 16'h0003 : 16'h0000);
        end
        $display("led done");
    endtask
    task automatic t_jab(input logic dis);
        wr(ADDR_AUX_CTRL_STAT, {dis, 15'h0000});
        spd = 0;
        txr = 1;
        repeat (24) @(negedge clk);
        chk("jab", 16'(jab), 16'(!dis));
        chk("drv", 16'(drv), 16'(dis));
        txr = 0;
        repeat (2) @(negedge clk);
        spd = 1;
        $display("jab done");
    endtask
    task automatic t_blk(input logic on);
        int n = 0;
        wr(ADDR_AUX_MODE, {14'h0000, on, 1'b0});
        txr = 1;
        repeat (3) @(negedge clk);
        txr = 0;
        repeat (3) @(negedge clk);
        txr = 1;
        repeat (10) begin
            @(negedge clk);
            n += idl;
        end
        chk("idles", 16'(n), on ? 16'h0002 : 16'h0000);
        txr = 0;
        repeat (6) @(negedge clk);
        $display("blk done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk);
        arst_n = 1;
        t_regs;
        t_edge;
        t_led;
        t_jab(1'b0);
        t_jab(1'b1);
        t_jab(1'b0);
        t_blk(1'b1);
        t_blk(1'b0);
        tally_and_finish;
    end
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        tally_and_finish;
    end
endmodule
